// [src/sss_sequencer.sv]
// Start-up, pin configuration and soft-start sequencer of the power module
//
// What this block does
// - Address low bits times 45 degrees give phase; CS mode gives zero
// - Bus-written phase in 22.5 degree steps overrides
// - Phase applies only against shared synchronised clock
// - Bus accepts output target from 0.6 to 3.6 V
// - Voltage pin: low 1.2, open 1.5, high 3.3
// - Bus target clamped to pin voltage plus ten percent
// - Five millisecond memory check loads stored values
// - After memory check, all strap pins are sampled
// - Enable and bus ignored during both checks
// - Restore command repeats the memory check
// - Then ready: bus and enable accepted
// - Nonzero delay below mode minimum is raised to it
// - Longer configured delay is waited in full
// - After delay, ramp over the configured time
// - Enable held from power-up still waits initialisation
// - Delay timed from enable until it elapses
// - Ramp is monotonic, at most 1 mV per clock, slope from ramp time; zero ramp time jumps to target
// - Soft-start pin read only at start-up or restore
// - Open soft-start pin gives 5 ms delay and ramp
// - Zero delay ramps about 2 ms after enable
// - Pins decode as low, open, high or 30 voltage, 32 address, 23 soft-start codes
`timescale 1ns/1ps
`default_nettype none
module sss_sequencer #(
  parameter logic [31:0] MS_CYCLES = 32'(sss_pkg::MS_CYC)
) (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic [sss_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [sss_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [sss_pkg::REG_DW-1:0] reg_rdata,
  input  wire logic                      en_in,
  input  wire logic                      sync_locked,
  input  wire logic                      nvm_user_vld,
  input  wire logic [11:0]               nvm_vout_mv,
  input  wire sss_pkg::sss_pin_t         vsel_state,
  input  wire logic [4:0]                vsel_code,
  input  wire sss_pkg::sss_pin_t         sa_state,
  input  wire logic [4:0]                sa_code,
  input  wire sss_pkg::sss_pin_t         ss_state,
  input  wire logic [4:0]                ss_code,
  output logic      [6:0]                bus_addr,
  output logic      [11:0]               vout_target_mv,
  output logic      [11:0]               vout_max_mv,
  output logic      [11:0]               vout_ref_mv,
  output logic      [3:0]                phase_idx,
  output logic                           dev_ready,
  output logic                           ramping,
  output logic                           power_on
);

  // ****************************************************
  // Pin decoding
  // ****************************************************
  function automatic logic [11:0] vsel_decode(sss_pkg::sss_pin_t st,
                                              logic [4:0] code);
    unique case (st)
      sss_pkg::PIN_LOW:  return sss_pkg::VOUT_LOW_MV;
      sss_pkg::PIN_OPEN: return sss_pkg::VOUT_OPEN_MV;
      sss_pkg::PIN_HIGH: return sss_pkg::VOUT_HIGH_MV;
      sss_pkg::PIN_RES:
        return (code < sss_pkg::VOUT_CODES) ? sss_pkg::VOUT_TBL[code]
                                           : sss_pkg::VOUT_MAX_MV;
    endcase
  endfunction

  function automatic logic [6:0] addr_decode(sss_pkg::sss_pin_t st,
                                             logic [4:0] code);
    unique case (st)
      sss_pkg::PIN_LOW:  return sss_pkg::ADDR_LOW;
      sss_pkg::PIN_OPEN: return sss_pkg::ADDR_OPEN;
      sss_pkg::PIN_HIGH: return sss_pkg::ADDR_HIGH;
      sss_pkg::PIN_RES:  return sss_pkg::ADDR_RES_BASE + 7'(code);
    endcase
  endfunction

  // Returns {delay, ramp} in milliseconds
  function automatic logic [15:0] ss_decode(sss_pkg::sss_pin_t st,
                                            logic [4:0] code);
    unique case (st)
      sss_pkg::PIN_LOW:
        return {sss_pkg::SS_LOW_DLY, sss_pkg::SS_LOW_RAMP};
      sss_pkg::PIN_OPEN:
        return {sss_pkg::SS_OPEN_MS, sss_pkg::SS_OPEN_MS};
      sss_pkg::PIN_HIGH:
        return {sss_pkg::SS_HIGH_MS, sss_pkg::SS_HIGH_MS};
      sss_pkg::PIN_RES:
        return (code < sss_pkg::SS_CODES)
               ? {sss_pkg::SS_DLY_TBL[code], sss_pkg::SS_RAMP_TBL[code]}
               : {sss_pkg::SS_OPEN_MS, sss_pkg::SS_OPEN_MS};
    endcase
  endfunction

  function automatic logic [11:0] clamp_vout(logic [15:0] v,
                                             logic [11:0] vmax);
    logic [11:0] lim;
    lim = (vmax < sss_pkg::VOUT_MAX_MV) ? vmax : sss_pkg::VOUT_MAX_MV;
    if (v < 16'(sss_pkg::VOUT_MIN_MV))
      return sss_pkg::VOUT_MIN_MV;
    else if (v > 16'(lim))
      return lim;
    else
      return v[11:0];
  endfunction

  function automatic logic [7:0] min_delay(logic cs, logic ac, logic lp);
    if (cs && (ac || lp))
      return sss_pkg::MIN_DLY_CS;
    else if (!cs && lp)
      return sss_pkg::MIN_DLY_LP;
    else
      return sss_pkg::MIN_DLY_BASE;
  endfunction

  // ****************************************************
  // Declarations
  // ****************************************************
  sss_pkg::sss_state_t state_r;
  sss_pkg::sss_state_t st_nxt;
  sss_tmr_if           tmr_if ();
  logic [11:0]         vpin_now;
  logic [11:0]         vmax_now;
  logic [11:0]         vmax_r;
  logic [11:0]         target_r;
  logic [11:0]         vref_r;
  logic [6:0]          addr_r;
  logic [7:0]          dly_ms_r;
  logic [7:0]          ramp_ms_r;
  logic [7:0]          eff_dly;
  logic [3:0]          phase_bus_r;
  logic                phase_ovr_r;
  logic [3:0]          phase_src;
  logic [3:0]          phase_r;
  logic                cs_r;
  logic                ac_r;
  logic                lp_r;
  logic                nvm_used_r;
  logic                bus_live;
  logic                wr_ok;
  logic                restore;
  logic [31:0]         ramp_total;
  logic [31:0]         acc_r;
  logic [32:0]         acc_sum;
  logic [sss_pkg::REG_DW-1:0] rd_mux;
  logic [sss_pkg::REG_DW-1:0] rdata_r;

  sss_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .mclk (mclk),
    .rstn (rstn),
    .tif  (tmr_if)
  );

  assign vpin_now = vsel_decode(vsel_state, vsel_code);
  assign vmax_now = vpin_now + vpin_now / sss_pkg::VMAX_DIV;
  assign bus_live = !(state_r inside {sss_pkg::ST_BOOT, sss_pkg::ST_NVM,
                                      sss_pkg::ST_PINS});
  assign wr_ok    = bus_live && reg_wr;
  assign restore  = wr_ok && (reg_addr == sss_pkg::REG_CTRL)
                    && reg_wdata[sss_pkg::CTRL_RESTORE];

  // Zero means a fixed 2 ms delay, not the mode minimum
  always_comb
  begin
    if (dly_ms_r == '0)
      eff_dly = sss_pkg::ZERO_DLY_MS;
    else if (dly_ms_r < min_delay(cs_r, ac_r, lp_r))
      eff_dly = min_delay(cs_r, ac_r, lp_r);
    else
      eff_dly = dly_ms_r;
  end

  // ****************************************************
  // Sequencer state machine
  // ****************************************************
  always_comb
  begin
    st_nxt = state_r;
    unique case (state_r)
      sss_pkg::ST_BOOT:  st_nxt = sss_pkg::ST_NVM;
      sss_pkg::ST_NVM:
        if (tmr_if.done)
          st_nxt = sss_pkg::ST_PINS;
      sss_pkg::ST_PINS:  st_nxt = sss_pkg::ST_READY;
      sss_pkg::ST_READY:
        if (en_in)
          st_nxt = sss_pkg::ST_DELAY;
      sss_pkg::ST_DELAY:
        if (!en_in)
          st_nxt = sss_pkg::ST_READY;
        else if (tmr_if.done)
          st_nxt = sss_pkg::ST_RAMP;
      sss_pkg::ST_RAMP:
        if (!en_in)
          st_nxt = sss_pkg::ST_READY;
        else if (vref_r >= target_r)
          st_nxt = sss_pkg::ST_ON;
      sss_pkg::ST_ON:
        if (!en_in)
          st_nxt = sss_pkg::ST_READY;
      default: st_nxt = sss_pkg::ST_BOOT;
    endcase
    if (restore)
      st_nxt = sss_pkg::ST_NVM;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_r <= sss_pkg::ST_BOOT;
    else
      state_r <= st_nxt;
  end

  assign tmr_if.start = (st_nxt != state_r) &&
                        (st_nxt inside {sss_pkg::ST_NVM, sss_pkg::ST_DELAY});
  assign tmr_if.ms    = (st_nxt == sss_pkg::ST_NVM) ? sss_pkg::NVM_CHECK_MS
                                                    : eff_dly;

  // ****************************************************
  // Configuration load and bus writes
  // ****************************************************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      vmax_r      <= sss_pkg::VOUT_MIN_MV;
      target_r    <= sss_pkg::VOUT_MIN_MV;
      addr_r      <= sss_pkg::ADDR_OPEN;
      dly_ms_r    <= sss_pkg::SS_OPEN_MS;
      ramp_ms_r   <= sss_pkg::SS_OPEN_MS;
      phase_bus_r <= '0;
      phase_ovr_r <= 1'b0;
      nvm_used_r  <= 1'b0;
    end
    else if (state_r == sss_pkg::ST_PINS)
    begin
      vmax_r                <= vmax_now;
      addr_r                <= addr_decode(sa_state, sa_code);
      {dly_ms_r, ramp_ms_r} <= ss_decode(ss_state, ss_code);
      phase_ovr_r           <= 1'b0;
      nvm_used_r            <= nvm_user_vld;
      target_r              <= nvm_user_vld
                               ? clamp_vout(16'(nvm_vout_mv), vmax_now)
                               : vpin_now;
    end
    else if (wr_ok)
    begin
      unique case (reg_addr)
        sss_pkg::REG_VOUT:
          target_r <= clamp_vout(reg_wdata, vmax_r);
        sss_pkg::REG_PHASE:
        begin
          phase_bus_r <= reg_wdata[3:0];
          phase_ovr_r <= 1'b1;
        end
        sss_pkg::REG_DELAY: dly_ms_r  <= reg_wdata[7:0];
        sss_pkg::REG_RAMP:  ramp_ms_r <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_r <= 1'b0;
      ac_r <= 1'b0;
      lp_r <= 1'b0;
    end
    else if (wr_ok && reg_addr == sss_pkg::REG_CTRL)
    begin
      cs_r <= reg_wdata[sss_pkg::CTRL_CS];
      ac_r <= reg_wdata[sss_pkg::CTRL_AC];
      lp_r <= reg_wdata[sss_pkg::CTRL_LP];
    end
  end

  // ****************************************************
  // Phase offset
  // ****************************************************
  // Address steps land on even indices of the 22.5 degree scale
  assign phase_src = phase_ovr_r ? phase_bus_r
                   : (cs_r ? '0 : {addr_r[2:0], 1'b0});

  // Without a locked common clock the offset has no reference
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      phase_r <= '0;
    else
      phase_r <= sync_locked ? phase_src : '0;
  end

  // ****************************************************
  // Soft-start ramp
  // ****************************************************
  // Rate is capped at one millivolt per clock unless ramp time is zero
  assign ramp_total = 32'(ramp_ms_r) * MS_CYCLES;
  assign acc_sum    = 33'(acc_r) + 33'(target_r);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      vref_r <= '0;
      acc_r  <= '0;
    end
    // Restore drops the output on the edge where the memory check starts again
    else if (restore)
    begin
      vref_r <= '0;
      acc_r  <= '0;
    end
    else if (state_r == sss_pkg::ST_ON)
      vref_r <= target_r;
    else if (state_r != sss_pkg::ST_RAMP)
    begin
      vref_r <= '0;
      acc_r  <= '0;
    end
    else if (ramp_ms_r == '0)
      vref_r <= target_r;
    else if (vref_r < target_r && acc_sum >= 33'(ramp_total))
    begin
      vref_r <= vref_r + 12'h001;
      acc_r  <= 32'(acc_sum - 33'(ramp_total));
    end
    else if (vref_r < target_r)
      acc_r <= acc_sum[31:0];
  end

  // ****************************************************
  // Register reads
  // ****************************************************
  always_comb
  begin
    unique case (reg_addr)
      sss_pkg::REG_CTRL:   rd_mux = 16'({lp_r, ac_r, cs_r, 1'b0});
      sss_pkg::REG_VOUT:   rd_mux = 16'(target_r);
      sss_pkg::REG_PHASE:  rd_mux = 16'({phase_ovr_r, phase_src});
      sss_pkg::REG_DELAY:  rd_mux = 16'(dly_ms_r);
      sss_pkg::REG_RAMP:   rd_mux = 16'(ramp_ms_r);
      sss_pkg::REG_STATUS: rd_mux = 16'({nvm_used_r, power_on, ramping,
                                         dev_ready});
      sss_pkg::REG_VMAX:   rd_mux = 16'(vmax_r);
      sss_pkg::REG_VREF:   rd_mux = 16'(vref_r);
      sss_pkg::REG_ADDR:   rd_mux = 16'(addr_r);
      default:             rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= '0;
    else
      rdata_r <= (bus_live && reg_rd) ? rd_mux : '0;
  end

  assign reg_rdata      = rdata_r;
  assign bus_addr       = addr_r;
  assign vout_target_mv = target_r;
  assign vout_max_mv    = vmax_r;
  assign vout_ref_mv    = vref_r;
  assign phase_idx      = phase_r;
  assign dev_ready      = bus_live;
  assign ramping        = (state_r == sss_pkg::ST_RAMP);
  assign power_on       = (state_r == sss_pkg::ST_ON);

  // ****************************************************
  // Assertions
  // ****************************************************
  AST_PHASE_ADDR: assert property (
    @(posedge mclk) disable iff (!rstn)
    (dev_ready && !phase_ovr_r && !cs_r && sync_locked)
      |=> phase_idx == {addr_r[2:0], 1'b0})
    else $error("phase does not follow address");

  AST_NO_PHASE_UNSYNC: assert property (
    @(posedge mclk) disable iff (!rstn)
    !sync_locked |=> phase_idx == '0)
    else $error("phase offset applied without common clock");

  AST_VOUT_LIMIT: assert property (
    @(posedge mclk) disable iff (!rstn)
    dev_ready |-> (vout_target_mv <= vout_max_mv &&
                   vout_target_mv >= sss_pkg::VOUT_MIN_MV &&
                   vout_target_mv <= sss_pkg::VOUT_MAX_MV))
    else $error("output target outside its limits");

  AST_QUIET_CHECK: assert property (
    @(posedge mclk) disable iff (!rstn)
    (!dev_ready && reg_rd) |=> reg_rdata == '0)
    else $error("bus answered during start-up check");

  AST_NO_EARLY_RAMP: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_r == sss_pkg::ST_NVM) |-> !ramping && !power_on
      && vout_ref_mv == '0)
    else $error("output moved before initialisation");

  AST_RESTORE_CHECK: assert property (
    @(posedge mclk) disable iff (!rstn)
    restore |=> state_r == sss_pkg::ST_NVM ##1 !dev_ready)
    else $error("restore did not repeat the memory check");

  AST_PINS_READY: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_r == sss_pkg::ST_PINS) |=> dev_ready)
    else $error("pin check not followed by ready");

  AST_MONOTONIC: assert property (
    @(posedge mclk) disable iff (!rstn)
    (ramping && $past(ramping)) |-> vout_ref_mv >= $past(vout_ref_mv))
    else $error("ramp went backwards");

  AST_SS_HELD: assert property (
    @(posedge mclk) disable iff (!rstn)
    (state_r != sss_pkg::ST_PINS && !wr_ok) |=> $stable(ramp_ms_r))
    else $error("ramp time changed without restore or write");

endmodule
`default_nettype wire

// [src/sss_pkg.sv]
// Constants, tables and types of the start-up soft-start sequencer
package sss_pkg;

  // ****************************************************
  // Clock and timing
  // ****************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned T_MS_NS       = 1000000;
  localparam int unsigned MS_CYC        = T_MS_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  NVM_CHECK_MS  = 8'h05;
  localparam logic [7:0]  ZERO_DLY_MS   = 8'h02;
  localparam logic [7:0]  MIN_DLY_BASE  = 8'h05;
  localparam logic [7:0]  MIN_DLY_LP    = 8'h0A;
  localparam logic [7:0]  MIN_DLY_CS    = 8'h0F;

  // ****************************************************
  // Register port
  // ****************************************************
  localparam int         REG_AW     = 4;
  localparam int         REG_DW     = 16;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_VOUT   = 4'h1;
  localparam logic [3:0] REG_PHASE  = 4'h2;
  localparam logic [3:0] REG_DELAY  = 4'h3;
  localparam logic [3:0] REG_RAMP   = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_VMAX   = 4'h6;
  localparam logic [3:0] REG_VREF   = 4'h7;
  localparam logic [3:0] REG_ADDR   = 4'h8;
  localparam int         CTRL_RESTORE = 0;
  localparam int         CTRL_CS      = 1;
  localparam int         CTRL_AC      = 2;
  localparam int         CTRL_LP      = 3;

  // ****************************************************
  // Output voltage
  // ****************************************************
  localparam logic [11:0] VOUT_MIN_MV  = 12'h258;
  localparam logic [11:0] VOUT_MAX_MV  = 12'hE10;
  localparam logic [11:0] VOUT_LOW_MV  = 12'h4B0;
  localparam logic [11:0] VOUT_OPEN_MV = 12'h5DC;
  localparam logic [11:0] VOUT_HIGH_MV = 12'hCE4;
  localparam logic [11:0] VMAX_DIV     = 12'h00A;
  localparam logic [4:0]  VOUT_CODES   = 5'h1E;
  localparam logic [11:0] VOUT_TBL [0:29] = '{
    12'h258, 12'h28A, 12'h2BC, 12'h2EE, 12'h320, 12'h352, 12'h384,
    12'h3B6, 12'h3E8, 12'h41A, 12'h44C, 12'h47E, 12'h4B0, 12'h4E2,
    12'h514, 12'h578, 12'h5DC, 12'h640, 12'h6A4, 12'h708, 12'h76C,
    12'h7D0, 12'h834, 12'h898, 12'h8FC, 12'h9C4, 12'hAF0, 12'hBB8,
    12'hCE4, 12'hE10};

  // ****************************************************
  // Bus address and soft-start tables
  // ****************************************************
  localparam logic [6:0] ADDR_LOW      = 7'h23;
  localparam logic [6:0] ADDR_OPEN     = 7'h24;
  localparam logic [6:0] ADDR_HIGH     = 7'h25;
  localparam logic [6:0] ADDR_RES_BASE = 7'h50;
  localparam logic [7:0] SS_LOW_DLY    = 8'h05;
  localparam logic [7:0] SS_LOW_RAMP   = 8'h02;
  localparam logic [7:0] SS_OPEN_MS    = 8'h05;
  localparam logic [7:0] SS_HIGH_MS    = 8'h0A;
  localparam logic [4:0] SS_CODES      = 5'h17;
  localparam logic [7:0] SS_DLY_TBL [0:22] = '{
    8'h05, 8'h05, 8'h0A, 8'h14, 8'h05, 8'h0A, 8'h14, 8'h05,
    8'h0A, 8'h05, 8'h0A, 8'h14, 8'h05, 8'h0A, 8'h14, 8'h05,
    8'h0A, 8'h05, 8'h0A, 8'h14, 8'h05, 8'h0A, 8'h14};
  localparam logic [7:0] SS_RAMP_TBL [0:22] = '{
    8'h02, 8'h05, 8'h05, 8'h05, 8'h0A, 8'h0A, 8'h0A, 8'h02,
    8'h02, 8'h05, 8'h05, 8'h05, 8'h0A, 8'h0A, 8'h0A, 8'h02,
    8'h02, 8'h05, 8'h05, 8'h05, 8'h0A, 8'h0A, 8'h0A};

  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {PIN_LOW, PIN_OPEN, PIN_HIGH, PIN_RES} sss_pin_t;
  typedef enum logic [2:0] {
    ST_BOOT, ST_NVM, ST_PINS, ST_READY, ST_DELAY, ST_RAMP, ST_ON
  } sss_state_t;

endpackage

// [src/sss_tmr_if.sv]
// Interface between the sequencer and its millisecond timer
`timescale 1ns/1ps
`default_nettype none
interface sss_tmr_if;
  logic       start;
  logic [7:0] ms;
  logic       done;
  modport ctl (output start, output ms, input done);
  modport tmr (input start, input ms, output done);
endinterface
`default_nettype wire

// [src/sss_ms_timer.sv]
// Millisecond interval timer for the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module sss_ms_timer #(
  parameter logic [31:0] MS_CYCLES = 32'(sss_pkg::MS_CYC)
) (
  input  wire logic mclk,
  input  wire logic rstn,
  sss_tmr_if.tmr    tif
);

  logic [31:0] cyc_r;
  logic [7:0]  ms_r;
  logic        done_r;

  // Idle timer reads as done; a start reloads it in the same edge
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_r  <= '0;
      ms_r   <= '0;
      done_r <= 1'b1;
    end
    else if (tif.start)
    begin
      cyc_r  <= '0;
      ms_r   <= tif.ms;
      done_r <= (tif.ms == '0);
    end
    else if (!done_r)
    begin
      if (cyc_r == MS_CYCLES - 32'h1)
      begin
        cyc_r  <= '0;
        ms_r   <= ms_r - 8'h01;
        done_r <= (ms_r == 8'h01);
      end
      else
        cyc_r <= cyc_r + 32'h1;
    end
  end

  assign tif.done = done_r;

endmodule
`default_nettype wire

// [testbench/sss_sys_model.sv]
// System enable and clock-lock model facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module sss_sys_model (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic en_req,
  input  wire logic lock_req,
  output logic      en_in,
  output logic      sync_locked
);
  // ****************
  // Enable is raised only after the shared clock is stable
  // ****************
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_locked <= 1'b0;
      en_in       <= 1'b0;
    end
    else
    begin
      sync_locked <= lock_req;
      en_in       <= en_req & sync_locked;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_sss_sequencer.sv]
// Self-checking bench of the start-up soft-start sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_sss_sequencer;
  logic mclk, rstn, reg_wr, reg_rd, en_req, lock_req, nvm_vld, en_in, lck;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  logic [11:0] nvm_mv, tgt, vmax, vref;
  logic [4:0]  vcode, acode, scode;
  logic [6:0]  baddr;
  logic [3:0]  phase;
  logic        rdy, ramping, pwr;
  sss_pkg::sss_pin_t vsel, sa, ss;
  int n_mismatch, n_compared;

  sss_sys_model i_sys (.mclk(mclk), .rstn(rstn), .en_req(en_req),
    .lock_req(lock_req), .en_in(en_in), .sync_locked(lck));
  sss_sequencer #(.MS_CYCLES(32'h0000000A)) i_dut (.mclk(mclk), .rstn(rstn),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .en_in(en_in), .sync_locked(lck),
    .nvm_user_vld(nvm_vld), .nvm_vout_mv(nvm_mv), .vsel_state(vsel),
    .vsel_code(vcode), .sa_state(sa), .sa_code(acode), .ss_state(ss),
    .ss_code(scode), .bus_addr(baddr), .vout_target_mv(tgt),
    .vout_max_mv(vmax), .vout_ref_mv(vref), .phase_idx(phase),
    .dev_ready(rdy), .ramping(ramping), .power_on(pwr));

  // ****************
  // Bus cycles and waits
  // ****************
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a; wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a; reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask
  task automatic cyc();
    @(posedge mclk);
    #1;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wait_rdy(output int n);
    n = 0;
    while (rdy !== 1'b1 && n < 100)
    begin
      cyc(); n++;
    end
    bound(n, 100);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_boot();
    int n;
    wait_rdy(n);
    `CHK(n >= 49 && n <= 54, 1'b1)
    `CHK(tgt, 12'h4B0)
    `CHK(vmax, 12'h528)
    `CHK(baddr, 7'h51)
    repeat (2) cyc();
    `CHK(phase, 4'h2)
    rd(sss_pkg::REG_DELAY, 16'h0005);
    rd(sss_pkg::REG_RAMP, 16'h0005);
    rd(sss_pkg::REG_ADDR, 16'h0051);
  endtask
  task automatic t_bus();
    wr(sss_pkg::REG_VOUT, 16'h0FA0);
    rd(sss_pkg::REG_VOUT, 16'h0528);
    wr(sss_pkg::REG_VOUT, 16'h02BC);
    rd(sss_pkg::REG_VOUT, 16'h02BC);
    wr(sss_pkg::REG_PHASE, 16'h0003);
    repeat (2) cyc();
    `CHK(phase, 4'h3)
    @(posedge mclk) lock_req <= 1'b0;
    repeat (3) cyc();
    `CHK(phase, 4'h0)
    lock_req <= 1'b1;
    rd(4'hF, 16'h0000);
  endtask
  task automatic t_enable();
    logic [15:0] ctl [5] = '{16'h0, 16'h0, 16'h0, 16'h8, 16'h6};
    logic [15:0] dly [5] = '{16'h0, 16'h1, 16'h7, 16'h1, 16'h1};
    int eff [5] = '{2, 5, 7, 10, 15};
    int n;
    logic [11:0] prev;
    for (int i = 0; i < 5; i++)
    begin
      wr(sss_pkg::REG_CTRL, ctl[i]);
      wr(sss_pkg::REG_DELAY, dly[i]);
      en_req <= 1'b1;
      n = 0;
      while (en_in !== 1'b1 && n < 10)
      begin
        cyc(); n++;
      end
      bound(n, 10);
      n = 0;
      while (ramping !== 1'b1 && n < 400)
      begin
        cyc(); n++;
      end
      bound(n, 400);
      `CHK(n >= eff[i]*10-1 && n <= eff[i]*10+3, 1'b1)
      prev = 12'h000;
      n = 0;
      while (pwr !== 1'b1 && n < 2000)
      begin
        cyc(); n++;
        `CHK(vref >= prev, 1'b1)
        prev = vref;
      end
      bound(n, 2000);
      `CHK(vref, 12'h2BC)
      en_req <= 1'b0;
      repeat (4) cyc();
      `CHK(vref, 12'h000)
    end
  endtask
  task automatic t_restore();
    int n;
    vsel <= sss_pkg::PIN_RES; vcode <= 5'h1E; sa <= sss_pkg::PIN_HIGH;
    ss <= sss_pkg::PIN_LOW; nvm_vld <= 1'b1; nvm_mv <= 12'h384;
    wr(sss_pkg::REG_CTRL, 16'h0001);
    cyc();
    `CHK(rdy, 1'b0)
    wr(sss_pkg::REG_VOUT, 16'h0258);
    rd(sss_pkg::REG_VOUT, 16'h0000);
    wait_rdy(n);
    `CHK(tgt, 12'h384)
    `CHK(vmax, 12'hF78)
    `CHK(baddr, 7'h25)
    repeat (2) cyc();
    `CHK(phase, 4'hA)
    rd(sss_pkg::REG_STATUS, 16'h0009);
    ss <= sss_pkg::PIN_HIGH;
    rd(sss_pkg::REG_DELAY, 16'h0005);
    rd(sss_pkg::REG_RAMP, 16'h0002);
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; addr = 4'h0; wdata = 16'h0;
    en_req = 1'b0; lock_req = 1'b1; nvm_vld = 1'b0; nvm_mv = 12'h000;
    vsel = sss_pkg::PIN_LOW; sa = sss_pkg::PIN_RES; ss = sss_pkg::PIN_OPEN;
    vcode = 5'h00; acode = 5'h01; scode = 5'h00;
    n_mismatch = 0; n_compared = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    t_boot();
    t_bus();
    t_enable();
    t_restore();
    summarize();
  end
endmodule
`default_nettype wire
